// >>> logic/frp_pkg.sv
// Constants, register map and state record for the flash readout
// protection and boot entry block.
// Assumes a 25 MHz bus clock and one AHB-Lite slave select per block.
package frp_pkg;

	// ==========================================================
	// Protection levels
	localparam logic [1:0] prot_open                  = 2'h0;
	localparam logic [1:0] prot_lock_any_downgrade    = 2'h1;
	localparam logic [1:0] prot_lock_loader_downgrade = 2'h2;
	localparam logic [1:0] prot_lock_permanent        = 2'h3;

	// ==========================================================
	// Memory arrays and boot bases
	localparam logic [31:0] MAIN_FLASH_BYTES = 32'h0001_0000;
	localparam logic [31:0] BOOT_MEM_BYTES   = 32'h0000_0800;
	localparam logic [31:0] MAIN_BASE        = 32'h0000_0000;
	localparam logic [31:0] BOOT_BASE        = 32'h0010_0000;
	localparam int          WP_W             = 8;
	localparam int          SECT_W           = 3;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_LEVEL    = 8'h04;
	localparam logic [7:0] OFS_INT_STAT = 8'h08;
	localparam logic [7:0] OFS_INT_MASK = 8'h0C;

	// Status register fields
	localparam int LVL_LO      = 0;
	localparam int LVL_BUSY    = 2;
	localparam int LVL_LOADER  = 3;
	localparam int LVL_BOOTED  = 4;

	// Interrupt bits
	localparam int INT_W          = 5;
	localparam int INT_PARITY     = 0;
	localparam int INT_REJECT     = 1;
	localparam int INT_RD_BLOCK   = 2;
	localparam int INT_WR_BLOCK   = 3;
	localparam int INT_ERASE_DONE = 4;

	// Reset values
	localparam logic [WP_W-1:0]  WP_RST   = 8'h00;
	localparam logic [INT_W-1:0] MASK_RST = 5'h00;

	// ==========================================================
	// Timing of the loader entry square wave
	localparam int CLK_KHZ        = 25000;
	localparam int SQW_FREQ_KHZ   = 50;
	localparam int SQW_WINDOW_US  = 5000;
	localparam int SQW_HALF_CYC   = CLK_KHZ / (2 * SQW_FREQ_KHZ);
	localparam int SQW_WINDOW_CYC = SQW_WINDOW_US * CLK_KHZ / 1000;
	localparam int TOG_MIN_DEF    = 16;
	localparam int WIN_W          = 20;
	localparam int GAP_W          = 10;
	localparam int TOG_W          = 8;

	// ==========================================================
	// State record
	typedef enum logic [1:0] {
		BOOT_LOAD,
		BOOT_WINDOW,
		BOOT_MAIN,
		BOOT_LOADER
	} frp_boot_t;

	typedef struct packed {
		frp_boot_t        boot;
		logic [1:0]       level;
		logic [WP_W-1:0]  wp;
		logic [INT_W-1:0] int_stat;
		logic [INT_W-1:0] int_mask;
		logic             erase_busy;
		logic             erase_req;
		logic [WIN_W-1:0] win_cnt;
		logic [GAP_W-1:0] gap_cnt;
		logic [TOG_W-1:0] tog_cnt;
		logic             rx_prev;
		logic             wr_pend;
		logic [7:0]       wr_ofs;
		logic [31:0]      rdata;
		logic             parity_exc;
		logic             opt_wr;
		logic [1:0]       opt_val;
	} frp_state_t;

endpackage

// >>> logic/frp_protect.sv
// Flash readout protection, erase/write protection, SRAM parity check
// and boot source selection, with an AHB-Lite register slave.
// Assumes opt_level is stable from reset release and a flash controller
// that answers mass_erase_req with a mass_erase_done pulse.
`timescale 1ns/1ns
`default_nettype none

// Function
// [RL1] Four protection levels; the level is raised by loader-path commands.
// [RL2] At open level, debug and loader paths may read main flash.
// [RL3] First lock blocks reads; downgrade to open allowed from either path.
// [RL4] Every permitted downgrade erases the whole flash before opening.
// [RL5] Second lock blocks reads; downgrade to open only over loader path.
// [RL6] Permanent lock blocks reads and refuses every downgrade.
// [RL7] Sector erase/write protection comes from a software control register.
// [RL8] SRAM parity generated and checked each access; error raises exception.
// [RL9] Main array 64K and boot array 2K, separate bases.
// [RL10] Exactly two startup sources: main flash or boot loader.
// [RL11] While the loader runs, the serial programming path is enabled.
// [RL12] Host holds reset and drives a 50 kHz square wave on rx.
// [RL13] 5 ms after reset release the loader mode is in force.
// [RL14] Above open level, external reads return nothing, flash unchanged.
// [RL15] Without a square wave after release, boot runs the main program.
module frp_protect
	import frp_pkg::*;
#(
	parameter int WIN_CYC = SQW_WINDOW_CYC,
	parameter int TOG_MIN = TOG_MIN_DEF
) (
	// Clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// Stored protection level
	input  wire logic [1:0]        opt_level,
	output logic                   opt_level_wr,
	output logic [1:0]             opt_level_val,
	// Level change commands
	input  wire logic              isp_level_cmd,
	input  wire logic [1:0]        isp_level_req,
	input  wire logic              dbg_level_cmd,
	input  wire logic [1:0]        dbg_level_req,
	// External flash reads
	input  wire logic              dbg_rd_req,
	input  wire logic              isp_rd_req,
	output logic                   dbg_rd_grant,
	output logic                   isp_rd_grant,
	// Flash program and erase
	input  wire logic              flash_wr_req,
	input  wire logic [SECT_W-1:0] flash_wr_sector,
	input  wire logic              flash_wr_ext,
	output logic                   flash_wr_grant,
	output logic                   mass_erase_req,
	input  wire logic              mass_erase_done,
	// SRAM parity
	input  wire logic [31:0]       sram_wr_data,
	output logic [3:0]             sram_wr_par,
	input  wire logic              sram_rd_valid,
	input  wire logic [31:0]       sram_rd_data,
	input  wire logic [3:0]        sram_rd_par,
	output logic                   parity_exc,
	// Boot
	input  wire logic              host_serial_rx_pin,
	output logic                   boot_done,
	output logic                   boot_from_loader,
	output logic                   isp_uart_en,
	output logic [31:0]            boot_base,
	// Interrupt
	output logic                   irq
);

	frp_state_t       st;
	frp_state_t       next_st;
	logic [3:0]       lane_err;
	logic             par_err;
	logic             rd_open;
	logic             in_loader;
	logic             loaded;
	logic             isp_ok;
	logic             rx_edge;
	logic             acc;
	logic [INT_W-1:0] ev;
	logic [INT_W-1:0] clr;

	// ==========================================================
	// SRAM parity, one bit per byte lane
	for (genvar i = 0; i < 4; i++) begin : g_lane
		assign sram_wr_par[i] = ^sram_wr_data[8*i +: 8]; // RL8
		assign lane_err[i]    = sram_rd_valid &
			(^sram_rd_data[8*i +: 8] ^ sram_rd_par[i]); // RL8
	end
	assign par_err = |lane_err;

	// ==========================================================
	// Gates
	assign loaded    = (st.boot != BOOT_LOAD);
	assign in_loader = (st.boot == BOOT_LOADER);
	// Reads stay shut until the stored level is known
	assign rd_open   = loaded && !st.erase_busy && (st.level == prot_open);
	assign isp_ok    = isp_level_cmd && in_loader;
	assign rx_edge   = host_serial_rx_pin ^ st.rx_prev;
	assign acc       = hsel && hready && htrans[1];

	assign dbg_rd_grant = dbg_rd_req && rd_open; // RL2
	assign isp_rd_grant = isp_rd_req && rd_open && in_loader; // RL14
	assign flash_wr_grant = flash_wr_req && loaded && !st.erase_busy &&
		!st.wp[flash_wr_sector] && (!flash_wr_ext || rd_open); // RL7

	// ==========================================================
	// Next state
	always_comb begin
		next_st           = st;
		next_st.erase_req = 1'b0;
		next_st.opt_wr    = 1'b0;
		next_st.parity_exc = par_err; // RL8
		next_st.rx_prev   = host_serial_rx_pin;
		ev  = '0;
		clr = '0;
		ev[INT_PARITY]   = par_err;
		ev[INT_RD_BLOCK] = (dbg_rd_req && !rd_open) ||
			(isp_rd_req && in_loader && !rd_open); // RL14
		ev[INT_WR_BLOCK] = flash_wr_req && !flash_wr_grant;

		case (st.boot)
			BOOT_LOAD: begin
				next_st.level   = opt_level;
				next_st.boot    = BOOT_WINDOW;
				next_st.win_cnt = '0;
				next_st.gap_cnt = '0;
				next_st.tog_cnt = '0;
			end
			BOOT_WINDOW: begin
				next_st.win_cnt = st.win_cnt + 1'b1;
				if (st.gap_cnt != '1) begin
					next_st.gap_cnt = st.gap_cnt + 1'b1;
				end
				// Edges only count when spaced like the 50 kHz wave
				if (rx_edge) begin // RL12
					next_st.gap_cnt = '0;
					if (st.gap_cnt >= GAP_W'(SQW_HALF_CYC / 2) &&
						st.gap_cnt <= GAP_W'(SQW_HALF_CYC * 2)) begin
						if (st.tog_cnt != '1) begin
							next_st.tog_cnt = st.tog_cnt + 1'b1;
						end
					end else begin
						next_st.tog_cnt = '0;
					end
				end
				if (st.win_cnt == WIN_W'(WIN_CYC - 2)) begin // RL13
					if (st.tog_cnt >= TOG_W'(TOG_MIN)) begin
						next_st.boot = BOOT_LOADER; // RL10
					end else begin
						next_st.boot = BOOT_MAIN; // RL15
					end
				end
			end
			BOOT_MAIN, BOOT_LOADER: begin
				next_st.boot = st.boot;
			end
			default: begin
				next_st.boot = BOOT_LOAD;
			end
		endcase

		// Level commands; loader path wins when both arrive together
		if (isp_ok) begin
			if (!loaded || st.erase_busy) begin
				ev[INT_REJECT] = 1'b1;
			end else if (isp_level_req > st.level) begin
				next_st.level   = isp_level_req; // RL1
				next_st.opt_wr  = 1'b1;
				next_st.opt_val = isp_level_req;
			end else if (isp_level_req == prot_open &&
				(st.level == prot_lock_any_downgrade ||
				st.level == prot_lock_loader_downgrade)) begin // RL5
				next_st.erase_busy = 1'b1; // RL4
				next_st.erase_req  = 1'b1;
			end else if (isp_level_req != st.level) begin
				ev[INT_REJECT] = 1'b1; // RL6
			end
		end
		if (dbg_level_cmd) begin
			if (!isp_ok && loaded && !st.erase_busy &&
				dbg_level_req == prot_open &&
				st.level == prot_lock_any_downgrade) begin // RL3
				next_st.erase_busy = 1'b1; // RL4
				next_st.erase_req  = 1'b1;
			end else if (isp_ok || dbg_level_req != st.level ||
				st.erase_busy) begin
				ev[INT_REJECT] = 1'b1; // RL5
			end
		end

		// Level opens only once the whole array is blank
		if (st.erase_busy && mass_erase_done) begin
			next_st.erase_busy = 1'b0;
			next_st.level      = prot_open; // RL4
			next_st.opt_wr     = 1'b1;
			next_st.opt_val    = prot_open;
			ev[INT_ERASE_DONE] = 1'b1;
		end

		// Bus data phase write
		if (st.wr_pend) begin
			case (st.wr_ofs)
				OFS_CTRL:     next_st.wp = hwdata[WP_W-1:0]; // RL7
				OFS_INT_MASK: next_st.int_mask = hwdata[INT_W-1:0];
				OFS_INT_STAT: clr = hwdata[INT_W-1:0];
				default:      clr = '0;
			endcase
		end
		// Set wins over a write-one clear in the same cycle
		next_st.int_stat = (st.int_stat & ~clr) | ev;

		// Bus address phase; read data captured here for zero wait
		next_st.wr_pend = acc && hwrite;
		next_st.wr_ofs  = haddr[7:0];
		if (acc && !hwrite) begin
			case (haddr[7:0])
				OFS_CTRL:     next_st.rdata = {24'h000000, st.wp};
				OFS_LEVEL:    next_st.rdata = {27'h0000000,
					(st.boot == BOOT_MAIN) || in_loader, in_loader,
					st.erase_busy, st.level};
				OFS_INT_STAT: next_st.rdata = {27'h0000000, st.int_stat};
				OFS_INT_MASK: next_st.rdata = {27'h0000000, st.int_mask};
				default:      next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// State register; level resets to the safest value until loaded
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st            <= '0;
			st.boot       <= BOOT_LOAD;
			st.level      <= prot_lock_permanent;
			st.wp         <= WP_RST;
			st.int_mask   <= MASK_RST;
			// Rx idles high; avoids a false edge right after release
			st.rx_prev    <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Outputs
	assign hreadyout        = 1'b1;
	assign hresp            = 1'b0;
	assign hrdata           = st.rdata;
	assign opt_level_wr     = st.opt_wr;
	assign opt_level_val    = st.opt_val;
	assign mass_erase_req   = st.erase_req;
	assign parity_exc       = st.parity_exc;
	assign boot_done        = (st.boot == BOOT_MAIN) || in_loader;
	assign boot_from_loader = in_loader;
	assign isp_uart_en      = in_loader; // RL11
	assign boot_base        = in_loader ? BOOT_BASE : MAIN_BASE; // RL9
	assign irq              = |(st.int_stat & st.int_mask);

	// ==========================================================
	// Checks
	logic [WIN_W-1:0] age;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			age <= '0;
		end else if (age != '1) begin
			age <= age + 1'b1;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_perm_level_hold: assert property ( // RL6
		loaded && st.level == prot_lock_permanent
		|=> st.level == prot_lock_permanent)
		else $error("permanent level was lowered");

	a_dbg_read_gate: assert property ( // RL2
		dbg_rd_grant |-> st.level == prot_open && !st.erase_busy)
		else $error("debug read granted while protected");

	a_isp_read_gate: assert property ( // RL14
		isp_rd_grant |-> st.level == prot_open && in_loader)
		else $error("loader read granted while protected");

	a_open_after_erase: assert property ( // RL4
		(loaded && st.level != prot_open) ##1 (st.level == prot_open)
		|-> $past(st.erase_busy) && $past(mass_erase_done))
		else $error("level opened without a finished erase");

	a_lock1_dbg_down: assert property ( // RL3
		loaded && !st.erase_busy && !isp_ok && dbg_level_cmd &&
		dbg_level_req == prot_open &&
		st.level == prot_lock_any_downgrade
		|=> mass_erase_req ##1 st.erase_busy && !mass_erase_req)
		else $error("debug downgrade from first lock not started");

	a_lock2_dbg_refused: assert property ( // RL5
		loaded && !st.erase_busy && !isp_ok && dbg_level_cmd &&
		st.level == prot_lock_loader_downgrade &&
		dbg_level_req != st.level
		|=> !mass_erase_req && st.int_stat[INT_REJECT])
		else $error("debug downgrade from second lock accepted");

	a_wp_sector: assert property ( // RL7
		flash_wr_grant |-> !st.wp[flash_wr_sector])
		else $error("write granted to protected sector");

	a_wp_block_flag: assert property ( // RL7
		flash_wr_req && st.wp[flash_wr_sector]
		|=> st.int_stat[INT_WR_BLOCK])
		else $error("protected sector write not flagged");

	a_parity_exc: assert property ( // RL8
		par_err |=> parity_exc && st.int_stat[INT_PARITY])
		else $error("parity error without exception");

	a_boot_window: assert property ( // RL13
		$rose(boot_done) |-> age == WIN_W'(WIN_CYC))
		else $error("boot decision not at end of window");

	a_main_default: assert property ( // RL15
		$rose(boot_done) && !boot_from_loader
		|-> $past(st.tog_cnt) < TOG_W'(TOG_MIN))
		else $error("main boot despite square wave");

	c_loader_boot: cover property ($rose(boot_from_loader));
	c_dbg_downgrade: cover property (
		dbg_level_cmd && st.level == prot_lock_any_downgrade
		##1 mass_erase_req);
	c_erase_done: cover property (st.erase_busy && mass_erase_done);
	c_parity: cover property (par_err);

endmodule

`default_nettype wire

// >>> tb/frp_host_model.sv
// Programming host stand-in: drives the loader-entry square wave on
// the shared serial receive pin while the bench asks for it.
// Assumes frp_pkg is compiled first and hclk is the block clock.
`timescale 1ns/1ns
`default_nettype none
module frp_host_model
	import frp_pkg::*;
#(
	parameter int HALF = SQW_HALF_CYC
) (
	// Clock
	input  wire logic hclk,
	// Request from bench
	input  wire logic sqw_en,
	// Serial pin
	output logic      host_serial_rx_pin
);
	int cnt = 0;

	// Released line rests high on its pull-up, never at the last value
	always @(posedge hclk) begin
		if (!sqw_en) begin
			cnt <= 0;
			host_serial_rx_pin <= 1'b1;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			host_serial_rx_pin <= !host_serial_rx_pin;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for frp_protect: boot choice, protection levels,
// write protect, parity and interrupt.
// Assumes frp_pkg and frp_host_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import frp_pkg::*;
;
	// ==========================================================
	// Signals
	localparam int WIN = 1200;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, sram_wr_data = 32'h0;
	logic [31:0] sram_rd_data = 32'h0, hrdata, boot_base;
	logic [1:0]  htrans = 2'h0, opt_level = 2'h0, opt_level_val;
	logic [1:0]  isp_level_req = 2'h0, dbg_level_req = 2'h0;
	logic [2:0]  hsize = 3'h2, flash_wr_sector = 3'h0;
	logic [3:0]  sram_rd_par = 4'h0, sram_wr_par;
	logic        isp_level_cmd = 1'b0, dbg_level_cmd = 1'b0;
	logic        dbg_rd_req = 1'b0, isp_rd_req = 1'b0, sqw_en = 1'b0;
	logic        flash_wr_req = 1'b0, flash_wr_ext = 1'b0;
	logic        sram_rd_valid = 1'b0, mass_erase_done = 1'b0;
	logic        hreadyout, hresp, opt_level_wr, dbg_rd_grant;
	logic        isp_rd_grant, flash_wr_grant, mass_erase_req, parity_exc;
	logic        boot_done, boot_from_loader, isp_uart_en, irq;
	logic        host_serial_rx_pin;
	logic [2:0]  ers_d = 3'h0;
	logic [1:0]  last_val = 2'h0;
	int          mismatches = 0, samples_checked = 0;
	int          n_wr = 0, n_ers = 0, cyc = 0;

	initial forever #20 hclk = !hclk;

	frp_protect #(.WIN_CYC(WIN), .TOG_MIN(2)) dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.opt_level, .opt_level_wr, .opt_level_val, .isp_level_cmd,
		.isp_level_req, .dbg_level_cmd, .dbg_level_req, .dbg_rd_req,
		.isp_rd_req, .dbg_rd_grant, .isp_rd_grant, .flash_wr_req,
		.flash_wr_sector, .flash_wr_ext, .flash_wr_grant,
		.mass_erase_req, .mass_erase_done, .sram_wr_data, .sram_wr_par,
		.sram_rd_valid, .sram_rd_data, .sram_rd_par, .parity_exc,
		.host_serial_rx_pin, .boot_done, .boot_from_loader,
		.isp_uart_en, .boot_base, .irq
	);

	frp_host_model host (.hclk, .sqw_en, .host_serial_rx_pin);

	// Flash controller stand-in; erase takes a few cycles
	always @(posedge hclk) begin
		ers_d <= {ers_d[1:0], mass_erase_req};
		mass_erase_done <= ers_d[2];
		if (mass_erase_req === 1'b1)
			n_ers++;
		if (opt_level_wr === 1'b1) begin
			n_wr++;
			last_val = opt_level_val;
		end
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			stop_test();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t %s: %h not %h", $time, m, got, exp);
		end
	endtask

	task automatic chk1(input logic got, exp, input string m);
		chk({31'h0, got}, {31'h0, exp}, m);
	endtask

	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		chk(r & m, e, "register read");
	endtask

	task automatic do_reset(input logic [1:0] lvl, input logic sq);
		int n;
		n = 0;
		@(posedge hclk);
		opt_level <= lvl;
		sqw_en <= sq;
		hresetn <= 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		do @(posedge hclk); while (boot_done !== 1'b1 && ++n < WIN + 200);
		sqw_en <= 1'b0;
		@(negedge hclk);
		chk1(boot_done, 1'b1, "boot decided");
	endtask

	task automatic lvl_cmd(input logic in_system_programming, input logic [1:0] r);
		@(posedge hclk);
		isp_level_cmd <= in_system_programming;
		dbg_level_cmd <= !in_system_programming;
		isp_level_req <= r;
		dbg_level_req <= r;
		@(posedge hclk);
		isp_level_cmd <= 1'b0;
		dbg_level_cmd <= 1'b0;
	endtask

	task automatic wait_wr(input int w0);
		int n;
		n = 0;
		while (n_wr == w0 && n < 60) begin
			@(posedge hclk);
			n++;
		end
		@(negedge hclk);
	endtask

	// Loader-path reads only exist while the loader runs
	task automatic grants(input logic ed, ei);
		@(posedge hclk);
		dbg_rd_req <= 1'b1;
		isp_rd_req <= 1'b1;
		@(negedge hclk);
		chk1(dbg_rd_grant, ed, "debug read grant");
		chk1(isp_rd_grant, ei, "loader read grant");
		@(posedge hclk);
		dbg_rd_req <= 1'b0;
		isp_rd_req <= 1'b0;
	endtask

	task automatic wr_try(input logic [2:0] s, input logic x, e);
		@(posedge hclk);
		flash_wr_req <= 1'b1;
		flash_wr_sector <= s;
		flash_wr_ext <= x;
		@(negedge hclk);
		chk1(flash_wr_grant, e, "flash write grant");
		@(posedge hclk);
		flash_wr_req <= 1'b0;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_boot_main;
		do_reset(prot_open, 1'b0);
		chk1(boot_from_loader, 1'b0, "loader chosen");
		chk(boot_base, MAIN_BASE, "boot base");
		rd_chk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
		rd_chk(OFS_INT_MASK, 32'hFFFF_FFFF, 32'h0);
		rd_chk(8'h10, 32'hFFFF_FFFF, 32'h0);
		chk1(hresp, 1'b0, "bus response");
		grants(1'b1, 1'b0);
		$display("test boot_main done");
	endtask

	task automatic t_wp;
		wr(OFS_CTRL, 32'h0000_0001);
		wr_try(3'h0, 1'b0, 1'b0);
		wr_try(3'h1, 1'b0, 1'b1);
		rd_chk(OFS_INT_STAT, 32'h8, 32'h8);
		$display("test write_protect done");
	endtask

	task automatic t_parity;
		logic [31:0] d;
		d = 32'h0000_0103;
		wr(OFS_INT_MASK, 32'h1);
		@(posedge hclk);
		sram_wr_data <= d;
		sram_rd_data <= d;
		sram_rd_par <= 4'h0;
		sram_rd_valid <= 1'b1;
		@(posedge hclk);
		sram_rd_valid <= 1'b0;
		@(negedge hclk);
		chk({28'h0, sram_wr_par}, {28'h0, ^d[31:24], ^d[23:16],
			^d[15:8], ^d[7:0]}, "write parity");
		chk1(parity_exc, 1'b1, "parity exception");
		chk1(irq, 1'b1, "irq raised");
		wr(OFS_INT_MASK, 32'h0);
		@(negedge hclk);
		chk1(irq, 1'b0, "irq masked");
		wr(OFS_INT_MASK, 32'h1);
		wr(OFS_INT_STAT, 32'h1);
		@(negedge hclk);
		chk1(irq, 1'b0, "irq cleared");
		$display("test parity done");
	endtask

	task automatic t_lock1;
		int e;
		int w;
		do_reset(prot_lock_any_downgrade, 1'b0);
		grants(1'b0, 1'b0);
		wr_try(3'h1, 1'b1, 1'b0);
		e = n_ers;
		w = n_wr;
		lvl_cmd(1'b0, prot_open);
		wait_wr(w);
		chk(n_ers - e, 1, "erase count");
		chk({30'h0, last_val}, {30'h0, prot_open}, "stored level");
		rd_chk(OFS_LEVEL, 32'h3, {30'h0, prot_open});
		grants(1'b1, 1'b0);
		wr_try(3'h1, 1'b1, 1'b1);
		$display("test lock1 done");
	endtask

	task automatic t_lock2;
		int w;
		do_reset(prot_lock_loader_downgrade, 1'b1);
		chk1(boot_from_loader, 1'b1, "loader chosen");
		chk1(isp_uart_en, 1'b1, "loader serial");
		chk(boot_base, BOOT_BASE, "boot base");
		lvl_cmd(1'b0, prot_open);
		repeat (3) @(posedge hclk);
		rd_chk(OFS_INT_STAT, 32'h2, 32'h2);
		rd_chk(OFS_LEVEL, 32'h3, {30'h0, prot_lock_loader_downgrade});
		w = n_wr;
		lvl_cmd(1'b1, prot_open);
		wait_wr(w);
		rd_chk(OFS_LEVEL, 32'h3, {30'h0, prot_open});
		grants(1'b1, 1'b1);
		$display("test lock2 done");
	endtask

	task automatic t_lock3;
		int w;
		int e;
		w = n_wr;
		lvl_cmd(1'b1, prot_lock_permanent);
		wait_wr(w);
		chk({30'h0, last_val}, {30'h0, prot_lock_permanent}, "raise");
		e = n_ers;
		lvl_cmd(1'b1, prot_open);
		repeat (8) @(posedge hclk);
		chk(n_ers - e, 0, "erase count");
		rd_chk(OFS_LEVEL, 32'h3, {30'h0, prot_lock_permanent});
		grants(1'b0, 1'b0);
		$display("test lock3 done");
	endtask

	initial begin
		t_boot_main();
		t_wp();
		t_parity();
		t_lock1();
		t_lock2();
		t_lock3();
		stop_test();
	end
endmodule
`default_nettype wire
